// ---- design/dbg_write_params.svh ----
// constants of the debug enclave word write block
`ifndef DBG_WRITE_PARAMS_SVH
`define DBG_WRITE_PARAMS_SVH

// register byte offsets on the wishbone slave
`define ADDR_CTRL        8'h00
`define ADDR_RESULT      8'h04
`define ADDR_DATA_LO     8'h08
`define ADDR_DATA_HI     8'h0c
`define ADDR_TARGET_LO   8'h10
`define ADDR_TARGET_HI   8'h14
`define ADDR_STATUS      8'h18
`define ADDR_FLAGS       8'h1c
`define ADDR_FAULT_LO    8'h20
`define ADDR_FAULT_HI    8'h24

// control register fields
`define CTRL_START       0
`define CTRL_LMA         1
`define CTRL_CSL         2
`define CTRL_SEG_UNUSE   3
`define CTRL_SEG_VIOL    4
`define CTRL_RESET       32'h0000_0000

// status register fields
`define STAT_BUSY        0
`define STAT_DONE        1
`define STAT_GP          2
`define STAT_PF          3
`define STAT_BAD_LEAF    4

// flag register fields, arithmetic flag layout
`define FLAG_CF          0
`define FLAG_PF          2
`define FLAG_AF          4
`define FLAG_ZF          6
`define FLAG_SF          7
`define FLAG_OF          11
`define FLAGS_RESET      32'h0000_0000

// leaf selector and result codes
`define LEAF_DEBUG_WRITE 32'h0000_0005
`define RESULT_OK        32'h0000_0000
`define PAGE_NOT_DEBUGGABLE_CODE 32'h0000_000a
`define RESULT_RESET     32'h0000_0000

// thread control page field limit
`define TCS_OFFSET_MASK  12'hff8
`define TCS_FLAGS_OFFSET 12'h008

// address space
`define VA_BITS          48
`define PAGE_SHIFT       12
`define EPC_BASE         64'h0000_0000_8000_0000
`define EPC_SIZE         64'h0000_0000_0100_0000

`endif

// ---- design/dbg_write_pkg.sv ----
// types shared by the debug enclave word write block
package dbg_write_pkg;

  typedef enum logic [7:0] {
    ENCLAVE_CONTROL_TYPE    = 8'h00,
    THREAD_PAGE_TYPE        = 8'h01,
    REGULAR_PAGE_TYPE       = 8'h02,
    VERSION_ARRAY_TYPE      = 8'h03,
    TRIMMED_PAGE_TYPE       = 8'h04,
    SHADOW_STACK_FIRST_TYPE = 8'h05,
    SHADOW_STACK_REST_TYPE  = 8'h06
  } page_type_t;

  typedef enum logic [2:0] {
    IDLE_S   = 3'b000,
    LOOKUP_S = 3'b001,
    CHECK_S  = 3'b010,
    ENCLAVE_CONTROL_PAGE_S   = 3'b011,
    WRITE_S  = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    CHK_OK     = 2'b00,
    CHK_PF     = 2'b01,
    CHK_NOTDBG = 2'b10,
    CHK_GP     = 2'b11
  } entry_check_t;

  typedef struct packed {
    logic        valid;
    page_type_t  pageType;
    logic        pending;
    logic        modified;
    logic [2:0]  rwx;
    logic [15:0] secsIndex;
  } page_entry_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [63:0] data;
    logic [7:0]  byteEn;
  } mem_wr_t;

  function automatic logic isWritableType(input page_type_t t);
    return (t == REGULAR_PAGE_TYPE) || (t == THREAD_PAGE_TYPE) ||
           (t == SHADOW_STACK_FIRST_TYPE) || (t == SHADOW_STACK_REST_TYPE);
  endfunction

endpackage

// ---- design/page_check.sv ----
// address and page metadata checks for the debug enclave word write
`include "dbg_write_params.svh"
module page_check
  import dbg_write_pkg::*;
(
  input  wire logic [63:0]  targetAddr,
  input  wire logic         mode64,
  input  wire logic         segUnusable,
  input  wire logic         segViolation,
  input  wire page_entry_t  entry,
  output logic              addrFault,
  output logic              resident,
  output entry_check_t      entryCheck
);

  function automatic logic misaligned(input logic [63:0] a, input logic [2:0] m);
    return (a[2:0] & m) != 3'h0;
  endfunction

  function automatic logic isCanonical(input logic [63:0] a);
    return (&a[63:`VA_BITS-1]) || !(|a[63:`VA_BITS-1]);
  endfunction

  logic tcsOffsetBad;

  // segment, canonical form and natural alignment all end in a protection fault
  always_comb begin
    addrFault = segUnusable || segViolation;
    if (mode64) begin
      addrFault = addrFault || misaligned(targetAddr, 3'h7);
      addrFault = addrFault || !isCanonical(targetAddr);
    end else begin
      addrFault = addrFault || misaligned(targetAddr, 3'h3);
    end
  end

  assign resident = (targetAddr >= `EPC_BASE) && (targetAddr < (`EPC_BASE + `EPC_SIZE));

  assign tcsOffsetBad = (targetAddr[11:0] & `TCS_OFFSET_MASK) != (`TCS_FLAGS_OFFSET & `TCS_OFFSET_MASK);

  // priority follows the fixed check order; rwx bits are never looked at
  always_comb begin
    if (!entry.valid) begin
      entryCheck = CHK_PF;
    end else if (!isWritableType(entry.pageType)) begin
      entryCheck = CHK_PF;
    end else if (entry.pending || entry.modified) begin
      entryCheck = CHK_NOTDBG;
    end else if ((entry.pageType == THREAD_PAGE_TYPE) && tcsOffsetBad) begin
      entryCheck = CHK_GP;
    end else begin
      entryCheck = CHK_OK;
    end
  end

endmodule

// ---- design/debug_enclave_word_write.sv ----
// debug enclave word write: checks the target page and writes one dword or quadword
// Notes on behaviour
// - the operation runs only when start is given with leaf selector 05H.
// - write eight bytes in 64-bit mode, else the low four bytes; size fixed.
// - 64-bit mode means long mode active and code segment long bit both set.
// - in 64-bit mode a target not 8-byte aligned gives protection fault, no write.
// - outside 64-bit mode a target not 4-byte aligned gives protection fault, no write.
// - in 64-bit mode a non-canonical target gives a protection fault.
// - unusable data segment or limit or rights violation gives a protection fault.
// - a target outside protected page memory gives a page fault with that address.
// - another operation modifying the same map entry gives a protection fault.
// - a map entry with valid clear gives a page fault with the address.
// - only regular, thread, first or later shadow-stack pages; others page fault.
// - a target in an enclave control page is refused and never written.
// - pending or modified page sets zero flag, returns not-debuggable code, skips write.
// - on a thread page the masked offset must hit the flags field, else protection fault.
// - owning enclave found through the map entry; debug attribute zero gives protection fault.
// - page read, write and execute permissions are ignored by this operation.
// - after a successful write the result is zero and the zero flag cleared.
// - success and error-code paths clear carry, parity, aux, overflow and sign flags.
// - measurement, add, init, accept, modify and tracking work never conflicts here.
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`include "dbg_write_params.svh"
module debug_enclave_word_write
  import dbg_write_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pageConflict,
  output logic             metaReq,
  output logic      [51:0] metaPage,
  input  wire logic        metaAck,
  input  wire page_entry_t metaEntry,
  output logic             secsReq,
  output logic      [15:0] secsIndex,
  input  wire logic        secsAck,
  input  wire logic        secsDebug,
  output logic             memReq,
  output mem_wr_t          memWr,
  input  wire logic        memAck
);

  function automatic logic [31:0] applySel(input logic [31:0] old, input logic [31:0] wdat,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wdat[8*i +: 8];
      end
    end
    return r;
  endfunction

  state_t       state_reg;
  state_t       state_next;
  logic         ackReg;
  logic [31:0]  rdData_reg;
  logic [31:0]  rdData_next;
  logic [31:0]  ctrl_reg;
  logic [31:0]  ctrlNow;
  logic [31:0]  result_reg;
  logic [31:0]  flags_reg;
  logic [63:0]  data_reg;
  logic [63:0]  target_reg;
  logic [63:0]  faultAddr_reg;
  page_entry_t  entry_reg;
  mem_wr_t      memWr_reg;
  logic         done_reg;
  logic         gp_reg;
  logic         pf_reg;
  logic         badLeaf_reg;
  logic         busWrite;
  logic         idle;
  logic         startWrite;
  logic         acceptStart;
  logic         badLeafStart;
  logic         mode64;
  logic         addrFault;
  logic         resident;
  entry_check_t entryCheck;
  logic         finishGp;
  logic         finishPf;
  logic         finishNotDbg;
  logic         finishOk;
  logic         enterWrite;

  // a write takes effect at the edge where the master sees ack
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && ackReg;
  assign idle     = (state_reg == IDLE_S);
  assign startWrite   = busWrite && (wb_adr_i == `ADDR_CTRL) && wb_sel_i[0] && wb_dat_i[`CTRL_START];
  assign acceptStart  = startWrite && idle && (result_reg == `LEAF_DEBUG_WRITE);
  assign badLeafStart = startWrite && idle && (result_reg != `LEAF_DEBUG_WRITE);
  // a control write is decoded as it lands, so a start is checked with the mode bits it carries;
  // configuration writes are refused while busy, so the decode stays stable during an operation
  assign ctrlNow = (busWrite && idle && (wb_adr_i == `ADDR_CTRL)) ?
                   (applySel(ctrl_reg, wb_dat_i, wb_sel_i) & 32'h0000_001e) : ctrl_reg;
  assign mode64 = ctrlNow[`CTRL_LMA] && ctrlNow[`CTRL_CSL];

  page_check u_check (
    .targetAddr   (target_reg),
    .mode64       (mode64),
    .segUnusable  (ctrlNow[`CTRL_SEG_UNUSE]),
    .segViolation (ctrlNow[`CTRL_SEG_VIOL]),
    .entry        (entry_reg),
    .addrFault    (addrFault),
    .resident     (resident),
    .entryCheck   (entryCheck)
  );

  // wishbone slave: one wait state, ack drops the cycle after it was given
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ackReg <= 1'b0;
    end else if (ce) begin
      ackReg <= wb_cyc_i && wb_stb_i && !ackReg;
    end
  end

  always_comb begin
    rdData_next = 32'h0000_0000;
    case (wb_adr_i)
      `ADDR_CTRL:      rdData_next = ctrl_reg;
      `ADDR_RESULT:    rdData_next = result_reg;
      `ADDR_DATA_LO:   rdData_next = data_reg[31:0];
      `ADDR_DATA_HI:   rdData_next = data_reg[63:32];
      `ADDR_TARGET_LO: rdData_next = target_reg[31:0];
      `ADDR_TARGET_HI: rdData_next = target_reg[63:32];
      `ADDR_STATUS:    rdData_next = {27'h0, badLeaf_reg, pf_reg, gp_reg, done_reg, !idle};
      `ADDR_FLAGS:     rdData_next = flags_reg;
      `ADDR_FAULT_LO:  rdData_next = faultAddr_reg[31:0];
      `ADDR_FAULT_HI:  rdData_next = faultAddr_reg[63:32];
      default:         rdData_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData_reg <= 32'h0000_0000;
    end else if (ce && wb_cyc_i && wb_stb_i && !ackReg) begin
      rdData_reg <= rdData_next;
    end
  end

  assign wb_ack_o = ackReg;
  assign wb_dat_o = rdData_reg;

  // software-owned operand registers, frozen while an operation runs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg   <= `CTRL_RESET;
      data_reg   <= 64'h0;
      target_reg <= 64'h0;
    end else if (ce && busWrite && idle) begin
      case (wb_adr_i)
        `ADDR_CTRL:      ctrl_reg <= ctrlNow;
        `ADDR_DATA_LO:   data_reg[31:0] <= applySel(data_reg[31:0], wb_dat_i, wb_sel_i);
        `ADDR_DATA_HI:   data_reg[63:32] <= applySel(data_reg[63:32], wb_dat_i, wb_sel_i);
        `ADDR_TARGET_LO: target_reg[31:0] <= applySel(target_reg[31:0], wb_dat_i, wb_sel_i);
        `ADDR_TARGET_HI: target_reg[63:32] <= applySel(target_reg[63:32], wb_dat_i, wb_sel_i);
        default:         ;
      endcase
    end
  end

  // check sequence; pageConflict only covers modifiers of this entry
  always_comb begin
    state_next   = state_reg;
    finishGp     = 1'b0;
    finishPf     = 1'b0;
    finishNotDbg = 1'b0;
    finishOk     = 1'b0;
    enterWrite   = 1'b0;
    case (state_reg)
      IDLE_S: begin
        if (acceptStart) begin
          if (addrFault) begin
            finishGp = 1'b1;
          end else if (!resident) begin
            finishPf = 1'b1;
          end else if (pageConflict) begin
            finishGp = 1'b1;
          end else begin
            state_next = LOOKUP_S;
          end
        end
      end
      LOOKUP_S: begin
        if (metaAck) begin
          state_next = CHECK_S;
        end
      end
      CHECK_S: begin
        state_next = IDLE_S;
        case (entryCheck)
          CHK_PF:     finishPf = 1'b1;
          CHK_NOTDBG: finishNotDbg = 1'b1;
          CHK_GP:     finishGp = 1'b1;
          default:    state_next = ENCLAVE_CONTROL_PAGE_S;
        endcase
      end
      ENCLAVE_CONTROL_PAGE_S: begin
        if (secsAck) begin
          if (!secsDebug) begin
            finishGp   = 1'b1;
            state_next = IDLE_S;
          end else begin
            enterWrite = 1'b1;
            state_next = WRITE_S;
          end
        end
      end
      WRITE_S: begin
        if (memAck) begin
          finishOk   = 1'b1;
          state_next = IDLE_S;
        end
      end
      default: state_next = IDLE_S;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= IDLE_S;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      entry_reg <= '0;
    end else if (ce && (state_reg == LOOKUP_S) && metaAck) begin
      entry_reg <= metaEntry;
    end
  end

  assign metaReq   = (state_reg == LOOKUP_S);
  assign metaPage  = target_reg[63:`PAGE_SHIFT];
  assign secsReq   = (state_reg == ENCLAVE_CONTROL_PAGE_S);
  assign secsIndex = entry_reg.secsIndex;

  // data is latched only once every check has passed
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      memWr_reg <= '0;
    end else if (ce && enterWrite) begin
      memWr_reg.addr <= target_reg;
      if (mode64) begin
        memWr_reg.data   <= data_reg;
        memWr_reg.byteEn <= 8'hff;
      end else begin
        memWr_reg.data   <= {32'h0000_0000, data_reg[31:0]};
        memWr_reg.byteEn <= 8'h0f;
      end
    end
  end

  assign memReq = (state_reg == WRITE_S);
  assign memWr  = memWr_reg;

  // result register: leaf selector in, return code out
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= `RESULT_RESET;
    end else if (ce) begin
      if (finishOk) begin
        result_reg <= `RESULT_OK;
      end else if (finishNotDbg) begin
        result_reg <= `PAGE_NOT_DEBUGGABLE_CODE;
      end else if (busWrite && idle && (wb_adr_i == `ADDR_RESULT)) begin
        result_reg <= applySel(result_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // faults leave the flags untouched, as an exception would
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= `FLAGS_RESET;
    end else if (ce) begin
      if (finishOk || finishNotDbg) begin
        flags_reg[`FLAG_ZF] <= finishNotDbg;
        flags_reg[`FLAG_CF] <= 1'b0;
        flags_reg[`FLAG_PF] <= 1'b0;
        flags_reg[`FLAG_AF] <= 1'b0;
        flags_reg[`FLAG_OF] <= 1'b0;
        flags_reg[`FLAG_SF] <= 1'b0;
      end else if (busWrite && idle && (wb_adr_i == `ADDR_FLAGS)) begin
        flags_reg <= applySel(flags_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_reg    <= 1'b0;
      gp_reg      <= 1'b0;
      pf_reg      <= 1'b0;
      badLeaf_reg <= 1'b0;
    end else if (ce) begin
      if (acceptStart || badLeafStart) begin
        done_reg    <= badLeafStart || finishGp || finishPf;
        gp_reg      <= finishGp;
        pf_reg      <= finishPf;
        badLeaf_reg <= badLeafStart;
      end else if (finishGp || finishPf || finishNotDbg || finishOk) begin
        done_reg <= 1'b1;
        gp_reg   <= finishGp;
        pf_reg   <= finishPf;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      faultAddr_reg <= 64'h0;
    end else if (ce && finishPf) begin
      faultAddr_reg <= target_reg;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn || !ce);

  a_leaf_gate: assert property (badLeafStart |=> badLeaf_reg && done_reg && idle && !memReq)
    else $error("wrong leaf selector started an operation");
  a_wide_data: assert property (memReq && mode64 |-> memWr.byteEn == 8'hff && memWr.data == data_reg)
    else $error("64-bit write lost bytes");
  a_mode_split: assert property (acceptStart && ctrlNow[`CTRL_LMA] && !ctrlNow[`CTRL_CSL] &&
                                 target_reg[2:0] == 3'h4 && !ctrlNow[`CTRL_SEG_UNUSE] && !pageConflict &&
                                 !ctrlNow[`CTRL_SEG_VIOL] |=> !gp_reg)
    else $error("long mode without long code segment treated as 64-bit");
  a_align_64: assert property (acceptStart && mode64 && target_reg[2:0] != 3'h0
                               |=> gp_reg && done_reg && idle)
    else $error("misaligned 64-bit target not faulted");
  a_align_32: assert property (acceptStart && !mode64 && target_reg[1:0] != 2'h0 |=> gp_reg && idle)
    else $error("misaligned 32-bit target not faulted");
  a_canonical: assert property (acceptStart && mode64 &&
                                !((&target_reg[63:47]) || !(|target_reg[63:47])) |=> gp_reg)
    else $error("non-canonical target not faulted");
  a_segment: assert property (acceptStart && (ctrlNow[`CTRL_SEG_UNUSE] || ctrlNow[`CTRL_SEG_VIOL])
                              |=> gp_reg && !pf_reg)
    else $error("segment problem not faulted");
  a_resident: assert property (acceptStart && !addrFault && !resident
                               |=> pf_reg && faultAddr_reg == $past(target_reg))
    else $error("non-resident target not page faulted");
  a_conflict: assert property (acceptStart && !addrFault && resident && pageConflict
                               |=> gp_reg && idle)
    else $error("entry conflict not faulted");
  a_invalid: assert property (state_reg == CHECK_S && !entry_reg.valid |=> pf_reg && done_reg)
    else $error("invalid entry not page faulted");
  a_bad_type: assert property (state_reg == CHECK_S && entry_reg.valid &&
                               !isWritableType(entry_reg.pageType) |=> pf_reg ##1 !memReq)
    else $error("unsupported page type not page faulted");
  a_control_page: assert property (state_reg == CHECK_S && entry_reg.pageType == ENCLAVE_CONTROL_TYPE
                                   |=> idle && !memReq && done_reg)
    else $error("control page target went on");
  a_pending: assert property (state_reg == CHECK_S && entryCheck == CHK_NOTDBG
                              |=> flags_reg[`FLAG_ZF] && result_reg == `PAGE_NOT_DEBUGGABLE_CODE && idle)
    else $error("pending or modified page mishandled");
  a_tcs_offset: assert property (state_reg == CHECK_S && entry_reg.valid && !entry_reg.pending &&
                                 !entry_reg.modified && entry_reg.pageType == THREAD_PAGE_TYPE &&
                                 (target_reg[11:0] & 12'hff8) != 12'h008 |=> gp_reg)
    else $error("thread page offset outside flags field not faulted");
  a_debug_attr: assert property (state_reg == ENCLAVE_CONTROL_PAGE_S && secsAck && !secsDebug |=> gp_reg && idle)
    else $error("non-debug enclave written");
  a_success: assert property (memReq && memAck
                              |=> result_reg == 32'h0 && !flags_reg[`FLAG_ZF] && done_reg && !gp_reg)
    else $error("success not reported");
  a_flags_clear: assert property (finishOk || finishNotDbg |=>
                                  flags_reg[`FLAG_CF] == 1'b0 && flags_reg[`FLAG_PF] == 1'b0 &&
                                  flags_reg[`FLAG_AF] == 1'b0 && flags_reg[`FLAG_OF] == 1'b0 &&
                                  flags_reg[`FLAG_SF] == 1'b0)
    else $error("arithmetic flags not cleared");
  a_checked_write: assert property (memReq |-> entry_reg.valid && !entry_reg.pending &&
                                    !entry_reg.modified && isWritableType(entry_reg.pageType))
    else $error("memory written before checks passed");

  c_success: cover property (memReq && memAck);
  c_not_debug: cover property (finishNotDbg);
  c_page_fault: cover property (state_reg == CHECK_S && entryCheck == CHK_PF);
  c_debug_fault: cover property (state_reg == ENCLAVE_CONTROL_PAGE_S && secsAck && !secsDebug);

endmodule

// ---- tb/page_store_model.sv ----
// far side model: page metadata map, owning enclave attribute, page memory
module page_store_model
  import dbg_write_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        slow,
  input  wire page_entry_t entry,
  input  wire logic        debugAttr,
  input  wire logic        metaReq,
  output logic             metaAck,
  output page_entry_t      metaEntry,
  input  wire logic        secsReq,
  output logic             secsAck,
  output logic             secsDebug,
  input  wire logic        memReq,
  output logic             memAck
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] waitCnt;
  // outside an answer the lines carry the inverse, so an early or late sample shows up
  assign metaEntry = metaAck ? entry : page_entry_t'(~entry);
  assign secsDebug = secsAck ? debugAttr : ~debugAttr;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      waitCnt <= 2'h0;
      metaAck <= 1'b0;
      secsAck <= 1'b0;
      memAck  <= 1'b0;
    end else begin
      metaAck <= 1'b0;
      secsAck <= 1'b0;
      memAck  <= 1'b0;
      if ((metaReq | secsReq | memReq) && !(metaAck | secsAck | memAck)) begin
        if (!slow || waitCnt == 2'h3) begin
          waitCnt <= 2'h0;
          metaAck <= metaReq;
          secsAck <= secsReq;
          memAck  <= memReq;
        end else begin
          waitCnt <= waitCnt + 2'h1;
        end
      end
    end
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench: register driven operations against the page store model
`include "dbg_write_params.svh"
module testbench
  import dbg_write_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         mclk = 1'b0, rstn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, chkRd = 1'b0;
  logic         conflict = 1'b0, slow = 1'b0, dbg = 1'b1;
  logic         wbAck, metaReq, metaAck, secsReq, secsAck, secsDebug, memReq, memAck;
  logic [7:0]   wbAdr = 8'h00;
  logic [31:0]  wbDat = 32'h0, wbDatO;
  page_entry_t  ent = '0, metaEntry;
  mem_wr_t      memWr;
  logic [51:0]  metaPage;
  logic [15:0]  secsIdx;
  logic [63:0]  tgtNow = 64'h0;
  logic [135:0] exQ[$], wrQ[$];
  int           miscompares = 0, checksDone = 0;
  debug_enclave_word_write dut_u (.mclk(mclk), .rstn(rstn), .ce(1'b1), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .pageConflict(conflict), .metaReq(metaReq), .metaPage(metaPage), .metaAck(metaAck), .metaEntry(metaEntry),
    .secsReq(secsReq), .secsIndex(secsIdx), .secsAck(secsAck), .secsDebug(secsDebug), .memReq(memReq),
    .memWr(memWr), .memAck(memAck));
  page_store_model far_u (.mclk(mclk), .rstn(rstn), .slow(slow), .entry(ent), .debugAttr(dbg),
    .metaReq(metaReq), .metaAck(metaAck), .metaEntry(metaEntry), .secsReq(secsReq), .secsAck(secsAck),
    .secsDebug(secsDebug), .memReq(memReq), .memAck(memAck));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic check(input logic [135:0] seen, input logic [135:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDat, chkRd} <= {2'b11, w, a, d, c};
    do begin
      @(posedge mclk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    r = wbDatO;
    {wbCyc, wbStb, wbWe, chkRd} <= 4'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wbx(1'b1, a, d, 1'b0, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    exQ.push_back(136'(e));
    wbx(1'b0, a, 32'h0, 1'b1, r);
  endtask
  // the watcher pairs each result with the oldest note; a write nobody expected fails
  always @(posedge mclk) begin
    if (wbAck === 1'b1 && chkRd === 1'b1) check(136'(wbDatO), exQ.pop_front());
    if (memReq === 1'b1 && memAck === 1'b1) check(memWr, wrQ.size() > 0 ? wrQ.pop_front() : '1);
    if (metaReq === 1'b1 && metaAck === 1'b1) check(136'(metaPage), 136'(tgtNow[63:12]));
    if (secsReq === 1'b1 && secsAck === 1'b1) check(136'(secsIdx), 136'(ent.secsIndex));
  end
  task automatic op(input string nm, input logic [4:0] ctl, input logic [63:0] tgt, input page_entry_t e,
                    input logic [31:0] st);
    logic [63:0] d;
    logic [31:0] r;
    logic        m64, ok, pend;
    int          n;
    d = {$urandom, $urandom};
    m64 = ctl[1] & ctl[2];
    ok = st == 32'h2;
    pend = e.pending | e.modified;
    tgtNow = tgt;
    ent <= e;
    if (ok && !pend) wrQ.push_back({tgt, m64 ? d : {32'h0, d[31:0]}, m64 ? 8'hff : 8'h0f});
    wr(`ADDR_DATA_LO, d[31:0]);
    wr(`ADDR_DATA_HI, d[63:32]);
    wr(`ADDR_TARGET_LO, tgt[31:0]);
    wr(`ADDR_TARGET_HI, tgt[63:32]);
    wr(`ADDR_RESULT, st == 32'h12 ? 32'h4 : `LEAF_DEBUG_WRITE);
    wr(`ADDR_FLAGS, 32'hfff);
    wr(`ADDR_CTRL, {27'h0, ctl} | 32'h1);
    n = 0;
    do begin
      wbx(1'b0, `ADDR_STATUS, 32'h0, 1'b0, r);
      n++;
    end while (r[`STAT_DONE] !== 1'b1 && n < 30);
    if (r[`STAT_DONE] !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    rd(`ADDR_STATUS, st);
    rd(`ADDR_RESULT, st == 32'h12 ? 32'h4 : !ok ? 32'h5 : pend ? `PAGE_NOT_DEBUGGABLE_CODE : `RESULT_OK);
    rd(`ADDR_FLAGS, !ok ? 32'hfff : pend ? 32'h76a : 32'h72a);
    if (st[`STAT_PF]) rd(`ADDR_FAULT_LO, tgt[31:0]);
    $display("test %s finished", nm);
  endtask
  initial begin
    page_entry_t rg, e;
    logic [4:0]  m;
    void'($urandom(38116));
    rg = '{1'b1, REGULAR_PAGE_TYPE, 1'b0, 1'b0, 3'b000, 16'h0003};
    m = 5'b00110;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rd(8'h40, 32'h0);
    op("bad leaf", m, 64'h8000_1000, rg, 32'h12);
    op("quad", m, 64'h8000_1ff8, rg, 32'h2);
    op("dword", 5'b00010, 64'h80ff_fffc, rg, 32'h2);
    op("align8", m, 64'h8000_1004, rg, 32'h6);
    op("align4", 5'b00000, 64'h8000_1002, rg, 32'h6);
    op("canon", m, 64'h0000_8000_8000_1000, rg, 32'h6);
    op("unusable", m | 5'h08, 64'h8000_1000, rg, 32'h6);
    op("limit", m | 5'h10, 64'h8000_1000, rg, 32'h6);
    op("outside", m, 64'h8100_0000, rg, 32'ha);
    op("order", m, 64'h7fff_fffc, rg, 32'h6);
    e = rg;
    e.valid = 1'b0;
    conflict <= 1'b1;
    op("conflict", m, 64'h8000_1000, e, 32'h6);
    conflict <= 1'b0;
    op("invalid", m, 64'h8000_1000, e, 32'ha);
    for (int t = 0; t < 7; t++) begin
      e = rg;
      e.pageType = page_type_t'(t);
      op("type", m, 64'h8000_2008, e, t inside {1, 2, 5, 6} ? 32'h2 : 32'ha);
    end
    e = rg;
    e.pending = 1'b1;
    op("pending", m, 64'h8000_1000, e, 32'h2);
    e = rg;
    e.modified = 1'b1;
    op("modified", 5'b00000, 64'h8000_1000, e, 32'h2);
    e = rg;
    e.pageType = THREAD_PAGE_TYPE;
    op("field", m, 64'h8000_2010, e, 32'h6);
    dbg <= 1'b0;
    op("nodebug", m, 64'h8000_1000, rg, 32'h6);
    dbg <= 1'b1;
    slow <= 1'b1;
    op("slow", m, 64'h8000_3000, rg, 32'h2);
    check(136'(wrQ.size()), 136'h0);
    report_and_stop();
  end
endmodule
